// ==== linear_sensor_serial_command_engine.sv ====
/*
 * Serial command engine of a 102-pixel linear sensor: byte receiver with
 * break detection, command decoder, register file, pixel reset / sample /
 * dump sequencing and the framed serial transmitter.
 * Assumes sys_clk is the serial clock itself and that serial_in is already
 * synchronous to it; the analog side presents integ_value for integ_index.
 */
`include "sensor_regs.svh"

// What this block does
// - ten zeros on serial_in reinitialise receiver
// - main reset aborts dump, resets pixels
// - serial_out held idle until settled after reset
// - integration starts after 22-clock pixel reset
// - sample resets integrators as it stores them
// - dump sends 102 framed pixels, LSB first
// - first pixel frame starts 44 clocks later
// - abort stops dump, resets pixels, drops samples
// - 0x12 is sample then dump
// - 0x16 is sample, dump and start
// - register write: 010 plus address, data byte
// - register read sends stored value LSB first
// - register read answer starts 4 clocks later
// - mode 0x10 sleeps, 0x00 wakes
// - sleep leaves command machines running
// - sample on rising, drive on falling edge
// - input needs no stop bit; output one
// - receiver and transmitter run independently
// - zone offsets, gains and mode register map
module linear_sensor_serial_command_engine (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic [7:0] integ_value,
    output logic [6:0] integ_index,
    output logic integ_capture,
    output logic integ_reset,
    output logic integ_run,
    output logic hold_valid,
    output logic dump_active,
    output logic sleep,
    output sensor_pkg::cfg_t analog_cfg
);

    sensor_pkg::engine_t st;
    sensor_pkg::engine_t n;
    logic byte_done;
    logic [7:0] rx_byte;
    logic brk;
    logic cmd;
    logic do_reset;
    logic do_abort;
    logic do_start;
    logic do_sample;
    logic do_dump;
    logic do_store;
    logic do_fetch;
    logic mem_re;
    logic [7:0] mem_rdata;
    logic buf_in_valid;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [7:0] buf_out_data;
    logic buf_flush;

    // unmapped addresses read as zero
    function automatic logic [7:0] reg_value(input sensor_pkg::cfg_t c, input logic [4:0] a);
        logic [7:0] v;
        v = 8'h00;
        for (int z = 0; z < `ZONE_COUNT; z++) begin
            if (a == 5'(`ZONE_STRIDE * z)) begin
                v = c.zone[z].offset;
            end
            if (a == 5'(`ZONE_STRIDE * z + `GAIN_SLOT)) begin
                v = {3'h0, c.zone[z].gain};
            end
        end
        if (a == `REG_MODE) begin
            v = c.mode;
        end
        return v;
    endfunction

    hold_mem u_hold (
        .sys_clk(sys_clk),
        .we(st.samp_busy),
        .waddr(st.samp_idx),
        .wdata(integ_value),
        .re(mem_re),
        .raddr(st.dump_idx),
        .rdata(mem_rdata)
    );

    word_buf u_buf (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .flush(buf_flush),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(st.rd_pend ? mem_rdata : st.reg_word),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    assign buf_in_valid = st.rd_pend || st.reg_push;
    assign buf_out_ready = (!st.tx_busy || st.tx_cnt == `TX_LAST_BIT) && st.out_wait == 6'h00;

    always_comb begin
        n = st;
        byte_done = 1'b0;
        rx_byte = st.rx_sh;
        // receiver: start bit then eight bits, no stop bit needed before the next start
        n.zero_run = serial_in ? 4'h0 : (st.zero_run == `BREAK_LEN ? st.zero_run : st.zero_run + 4'h1);
        unique case (st.rx_st)
            sensor_pkg::RX_IDLE: begin
                if (!serial_in) begin
                    n.rx_st = sensor_pkg::RX_BITS;
                    n.rx_cnt = 4'h0;
                end
            end
            sensor_pkg::RX_BITS: begin
                n.rx_sh = {serial_in, st.rx_sh[7:1]};
                n.rx_cnt = st.rx_cnt + 4'h1;
                if (st.rx_cnt == `RX_LAST_BIT) begin
                    byte_done = 1'b1;
                    rx_byte = n.rx_sh;
                    n.rx_st = sensor_pkg::RX_IDLE;
                end
            end
            sensor_pkg::RX_HOLD: begin
                if (serial_in) begin
                    n.rx_st = sensor_pkg::RX_IDLE;
                end
            end
        endcase
        // a break drops any half-received command and waits for the line to rise
        brk = !serial_in && st.zero_run == `BREAK_LEN - 4'h1;
        if (brk) begin
            n.rx_st = sensor_pkg::RX_HOLD;
            n.want_data = 1'b0;
            byte_done = 1'b0;
        end

        cmd = byte_done && !st.want_data;
        do_reset = cmd && rx_byte == `CMD_MAIN_RESET;
        do_abort = cmd && rx_byte == `CMD_DUMP_ABORT;
        do_start = cmd && (rx_byte == `CMD_BEGIN_INTEGRATE || rx_byte == `CMD_SAMPLE_DUMP_RESTART);
        do_sample = cmd && (rx_byte == `CMD_SAMPLE_HOLD || rx_byte == `CMD_SAMPLE_DUMP
                    || rx_byte == `CMD_SAMPLE_DUMP_RESTART);
        do_dump = cmd && (rx_byte == `CMD_PIXEL_DUMP || rx_byte == `CMD_SAMPLE_DUMP
                  || rx_byte == `CMD_SAMPLE_DUMP_RESTART);
        do_store = cmd && rx_byte[`CMD_KIND_MSB:`CMD_KIND_LSB] == `KIND_REG_STORE;
        do_fetch = cmd && rx_byte[`CMD_KIND_MSB:`CMD_KIND_LSB] == `KIND_REG_FETCH;

        // register write: address byte, then data byte
        if (do_store) begin
            n.want_data = 1'b1;
            n.wr_addr = rx_byte[`ADDR_MSB:0];
        end
        if (byte_done && st.want_data) begin
            n.want_data = 1'b0;
            for (int z = 0; z < `ZONE_COUNT; z++) begin
                if (st.wr_addr == 5'(`ZONE_STRIDE * z)) begin
                    n.cfg.zone[z].offset = rx_byte;
                end
                if (st.wr_addr == 5'(`ZONE_STRIDE * z + `GAIN_SLOT)) begin
                    n.cfg.zone[z].gain = rx_byte[`GAIN_MSB:0];
                end
            end
            if (st.wr_addr == `REG_MODE) begin
                n.cfg.mode = rx_byte;
            end
        end

        // output delay counter shared by dump and register read
        if (st.out_wait != 6'h00) begin
            n.out_wait = st.out_wait - 6'h01;
        end
        if (do_fetch) begin
            n.reg_push = 1'b1;
            n.reg_word = reg_value(st.cfg, rx_byte[`ADDR_MSB:0]);
            n.out_wait = `FETCH_DELAY - 6'h01;
        end

        // pixel reset cycle ahead of integration
        if (st.start_pend) begin
            if (st.pixrst_cnt == 5'h00) begin
                n.start_pend = 1'b0;
                n.integ_reset = 1'b0;
                n.integ_run = 1'b1;
            end else begin
                n.pixrst_cnt = st.pixrst_cnt - 5'h01;
            end
        end

        // sample: copy one pixel a clock into the hold store
        if (st.samp_busy) begin
            n.samp_idx = st.samp_idx + 7'h01;
            if (st.samp_idx == `LAST_PIXEL) begin
                n.samp_busy = 1'b0;
                n.hold_valid = 1'b1;
            end
        end
        if (do_sample) begin
            n.samp_busy = 1'b1;
            n.samp_idx = 7'h00;
            n.hold_valid = 1'b0;
            n.integ_run = 1'b0;
            n.integ_reset = 1'b1;
        end
        if (do_start) begin
            n.start_pend = 1'b1;
            n.pixrst_cnt = `PIXRST_CLKS - 5'h01;
            n.integ_reset = 1'b1;
            n.integ_run = 1'b0;
        end

        // dump: a read never overtakes the sample copy
        mem_re = st.dump_busy && (!st.samp_busy || st.dump_idx < st.samp_idx)
                 && (!st.rd_pend || buf_in_ready);
        if (st.rd_pend && buf_in_ready) begin
            n.rd_pend = 1'b0;
        end else if (st.reg_push && buf_in_ready) begin
            n.reg_push = 1'b0;
        end
        if (mem_re) begin
            n.rd_pend = 1'b1;
            n.dump_idx = st.dump_idx + 7'h01;
            if (st.dump_idx == `LAST_PIXEL) begin
                n.dump_busy = 1'b0;
            end
        end
        if (do_dump) begin
            n.dump_busy = 1'b1;
            n.dump_idx = 7'h00;
            n.out_wait = `DUMP_DELAY - 6'h01;
        end

        // transmitter: start bit, eight bits LSB first, one stop bit, back to back
        if (st.tx_busy) begin
            n.tx_sh = {1'b1, st.tx_sh[9:1]};
            n.tx_cnt = st.tx_cnt + 4'h1;
            if (st.tx_cnt == `TX_LAST_BIT) begin
                n.tx_busy = 1'b0;
            end
        end
        if (buf_out_ready && buf_out_valid) begin
            n.tx_sh = {1'b1, buf_out_data, 1'b0};
            n.tx_cnt = 4'h0;
            n.tx_busy = 1'b1;
        end

        buf_flush = do_reset || do_abort;
        if (do_reset || do_abort) begin
            n.dump_busy = 1'b0;
            n.rd_pend = 1'b0;
            n.reg_push = 1'b0;
            n.tx_busy = 1'b0;
            n.tx_sh = `TX_IDLE_WORD;
            n.out_wait = 6'h00;
            n.samp_busy = 1'b0;
            n.hold_valid = 1'b0;
            n.start_pend = 1'b0;
            n.integ_run = 1'b0;
            n.integ_reset = 1'b1;
        end

        // serial_out is only trusted once the first main reset has settled
        if (do_reset) begin
            n.seen_reset = 1'b1;
        end
        if (st.seen_reset && !st.settled) begin
            if (st.settle_cnt == `SETTLE_CLKS - 5'h01) begin
                n.settled = 1'b1;
            end else begin
                n.settle_cnt = st.settle_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.rx_st <= sensor_pkg::RX_HOLD;
            st.integ_reset <= 1'b1;
            st.tx_sh <= `TX_IDLE_WORD;
        end else begin
            st <= n;
        end
    end

    // output changes on the falling edge so the controller samples a stable bit
    always_ff @(negedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            serial_out <= 1'b1;
        end else begin
            serial_out <= st.settled ? st.tx_sh[0] : 1'b1;
        end
    end

    assign integ_index = st.samp_idx;
    assign integ_capture = st.samp_busy;
    assign integ_reset = st.integ_reset;
    assign integ_run = st.integ_run;
    assign hold_valid = st.hold_valid;
    assign dump_active = st.dump_busy || st.tx_busy;
    assign sleep = st.cfg.mode[`MODE_SLEEP_BIT];
    assign analog_cfg = st.cfg;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_break;
        (!serial_in) [*8] ##1 !serial_in ##1 !serial_in;
    endsequence
    sequence s_frame;
        !st.tx_sh[0] ##9 st.tx_sh[0];
    endsequence

    break_rearm_a: assert property (s_break |=> st.rx_st == sensor_pkg::RX_HOLD)
        else $error("break did not rearm the receiver");
    reset_abort_a: assert property (do_reset |=> !st.dump_busy && st.integ_reset && !st.hold_valid)
        else $error("main reset left dump or samples alive");
    settle_gate_a: assert property (!st.settled |=> serial_out)
        else $error("serial_out driven before settling");
    pixel_reset_a: assert property (do_start && !do_reset |=> !st.integ_run [*8] ##15 st.integ_run)
        else $error("integration not released after pixel reset");
    sample_done_a: assert property (do_sample |=> st.integ_reset && !st.hold_valid ##102 st.hold_valid)
        else $error("sample copy did not finish in time");
    frame_shape_a: assert property ($rose(st.tx_busy) |-> s_frame)
        else $error("pixel frame lacks start or stop bit");
    dump_delay_a: assert property (do_dump && !st.tx_busy && !buf_out_valid |-> ##45 !st.tx_sh[0] && st.tx_busy)
        else $error("first pixel frame not at 44 clocks");
    abort_stop_a: assert property (do_abort |=> !st.dump_busy && !st.tx_busy && st.integ_reset)
        else $error("abort did not stop the dump");
    fetch_delay_a: assert property (do_fetch && !st.tx_busy && !st.dump_busy && !buf_out_valid
                                    |-> ##5 st.tx_busy && st.tx_cnt == 4'h0)
        else $error("register answer not at 4 clocks");
    sleep_set_a: assert property (byte_done && st.want_data && st.wr_addr == `REG_MODE
                                  && rx_byte == 8'h10 |=> sleep)
        else $error("mode write did not enter sleep");

endmodule

// ==== sensor_regs.svh ====
/*
 * Command codes, register addresses, field positions and serial clock counts
 * of the linear sensor command engine. Included by every design file that
 * needs them; holds definitions only.
 */
`ifndef SENSOR_REGS_SVH
`define SENSOR_REGS_SVH

`define CMD_MAIN_RESET 8'h1b
`define CMD_BEGIN_INTEGRATE 8'h08
`define CMD_SAMPLE_HOLD 8'h10
`define CMD_PIXEL_DUMP 8'h02
`define CMD_DUMP_ABORT 8'h19
`define CMD_SAMPLE_DUMP 8'h12
`define CMD_SAMPLE_DUMP_RESTART 8'h16

`define CMD_KIND_MSB 7
`define CMD_KIND_LSB 5
`define KIND_REG_STORE 3'h2
`define KIND_REG_FETCH 3'h3
`define ADDR_MSB 4

`define ZONE_COUNT 3
`define ZONE_STRIDE 2
`define GAIN_SLOT 1
`define GAIN_MSB 4
`define REG_MODE 5'h1f
`define MODE_SLEEP_BIT 4

`define BREAK_LEN 4'ha
`define PIXRST_CLKS 5'h16
`define DUMP_DELAY 6'h2c
`define FETCH_DELAY 6'h04
`define SETTLE_CLKS 5'h1e
`define LAST_PIXEL 7'h65
`define RX_LAST_BIT 4'h7
`define TX_LAST_BIT 4'h9
`define TX_IDLE_WORD 10'h3ff
`define BUF_DEPTH 2'h2

`endif

// ==== sensor_pkg.sv ====
/*
 * Types of the linear sensor command engine: register carrier, receiver
 * states and the packed state records of the engine and the word buffer.
 * Assumes sensor_regs.svh sits in the same folder.
 */
package sensor_pkg;

    typedef struct packed {
        logic [7:0] offset;
        logic [4:0] gain;
    } zone_cfg_t;

    typedef struct packed {
        zone_cfg_t [2:0] zone;
        logic [7:0] mode;
    } cfg_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_BITS = 3'b010,
        RX_HOLD = 3'b100
    } rx_state_t;

    typedef struct packed {
        rx_state_t rx_st;
        logic [3:0] rx_cnt;
        logic [7:0] rx_sh;
        logic [3:0] zero_run;
        logic want_data;
        logic [4:0] wr_addr;
        cfg_t cfg;
        logic integ_reset;
        logic integ_run;
        logic start_pend;
        logic [4:0] pixrst_cnt;
        logic samp_busy;
        logic [6:0] samp_idx;
        logic hold_valid;
        logic dump_busy;
        logic [6:0] dump_idx;
        logic rd_pend;
        logic reg_push;
        logic [7:0] reg_word;
        logic [5:0] out_wait;
        logic tx_busy;
        logic [3:0] tx_cnt;
        logic [9:0] tx_sh;
        logic seen_reset;
        logic [4:0] settle_cnt;
        logic settled;
    } engine_t;

    typedef struct packed {
        logic [7:0] head;
        logic [7:0] tail;
        logic [1:0] fill;
    } buf_state_t;

endpackage

// ==== hold_mem.sv ====
/*
 * Pixel hold store: one 8-bit word per pixel, one write and one read port.
 * Read data come from a register and only change when a read is enabled,
 * so a stalled reader keeps its word.
 */
`include "sensor_regs.svh"

module hold_mem (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic re,
    input wire logic [6:0] raddr,
    output logic [7:0] rdata
);

    logic [7:0] mem [0:`LAST_PIXEL];

    // no reset on the array: held values are meaningless until sampled anyway
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end

endmodule

// ==== word_buf.sv ====
/*
 * Two-entry word buffer between the word sources and the serialiser.
 * Valid/ready on both sides; flush empties it at once and wins over a push.
 */
`include "sensor_regs.svh"

module word_buf (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data
);

    sensor_pkg::buf_state_t st;
    sensor_pkg::buf_state_t n;
    logic push;
    logic pop;

    assign in_ready = (st.fill != `BUF_DEPTH);
    assign out_valid = (st.fill != 2'h0);
    assign out_data = st.head;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        n = st;
        unique case ({push, pop})
            2'b10: begin
                if (st.fill == 2'h0) begin
                    n.head = in_data;
                end else begin
                    n.tail = in_data;
                end
                n.fill = st.fill + 2'h1;
            end
            2'b01: begin
                n.head = st.tail;
                n.fill = st.fill - 2'h1;
            end
            2'b11: begin
                if (st.fill == 2'h1) begin
                    n.head = in_data;
                end else begin
                    n.head = st.tail;
                    n.tail = in_data;
                end
            end
            2'b00: ;
        endcase
        if (flush) begin
            n.fill = 2'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= n;
        end
    end

endmodule

// ==== serial_controller_model.sv ====
/*
 * Controller model for the serial command link: drives serial_in and reads
 * framed words from serial_out.
 * Assumes one free-running serial clock. The bench drives through one task
 * at a time, and receiving may run beside driving.
 */
module serial_controller_model (
    input wire logic sys_clk,
    input wire logic serial_out,
    output logic serial_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle high from power-up so the receiver clears before any start bit
    initial serial_in = 1'b1;

    // set just after a rising edge, sampled by the device at the next one
    task automatic drive_bits(input logic [31:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            serial_in <= bits[i];
        end
    endtask

    // zero start bit, then data lsb first; no stop bit, so bytes may abut
    task automatic send_byte(input logic [7:0] b);
        drive_bits({23'h0, b, 1'b0}, 9);
    endtask

    // high clocks after a command give the device time to finish
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            serial_in <= 1'b1;
        end
    endtask

    // start, eight data bits, stop, read at rising edges while the device drives on falling
    task automatic rx_frame(output logic [9:0] f);
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            f[i] = serial_out;
        end
    endtask
endmodule

// ==== linear_sensor_serial_command_engine_tb.sv ====
/*
 * Self-checking bench of the linear sensor command engine. Commands go out
 * through the controller model. Answers, their timing and the pins are compared.
 * Assumes the design files and serial_controller_model.sv compile first.
 */
`include "sensor_regs.svh"

module linear_sensor_serial_command_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic serial_in;
    logic serial_out;
    logic [7:0] integ_value;
    logic [6:0] integ_index;
    logic integ_capture;
    logic integ_reset;
    logic integ_run;
    logic hold_valid;
    logic dump_active;
    logic sleep;
    sensor_pkg::cfg_t analog_cfg;
    sensor_pkg::cfg_t exp_cfg;
    int mismatches = 0;
    int compares = 0;
    logic [9:0] frm;
    logic [4:0] addrs [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, `REG_MODE, 5'h06};
    logic [7:0] vals [8] = '{8'ha5, 8'h3c, 8'h5a, 8'he7, 8'hc3, 8'h0e, 8'h00, 8'h77};

    always #25 sys_clk = ~sys_clk;

    // converter stand-in: each pixel has its own value, so order faults show
    assign integ_value = {1'b0, integ_index} ^ 8'h5a;

    linear_sensor_serial_command_engine dut (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .integ_value(integ_value),
        .integ_index(integ_index),
        .integ_capture(integ_capture),
        .integ_reset(integ_reset),
        .integ_run(integ_run),
        .hold_valid(hold_valid),
        .dump_active(dump_active),
        .sleep(sleep),
        .analog_cfg(analog_cfg)
    );

    serial_controller_model ctl (.sys_clk(sys_clk), .serial_out(serial_out), .serial_in(serial_in));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // returns at the k-th rising edge after the edge that took the last bit
    task automatic cmd_at(input logic [7:0] c, input int k);
        ctl.send_byte(c);
        ctl.idle(k + 1);
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [7:0] v);
        ctl.send_byte({`KIND_REG_STORE, a});
        // a zero byte abutting the address byte would make ten zeros, a break
        if (v == 8'h00) ctl.idle(1);
        ctl.send_byte(v);
        ctl.idle(6);
    endtask

    task automatic reg_read(input logic [4:0] a, input logic [7:0] exp);
        cmd_at({`KIND_REG_FETCH, a}, 4);
        check("fetch lead", serial_out, 1'b1);
        ctl.rx_frame(frm);
        check("fetch word", frm, {1'b1, exp, 1'b0});
        ctl.idle(5);
    endtask

    task automatic dump_frames(input int n);
        for (int k = 0; k < n; k++) begin
            ctl.rx_frame(frm);
            check("pixel frame", frm, {1'b1, {1'b0, 7'(k)} ^ 8'h5a, 1'b0});
        end
    endtask

    // looks at falling edges so the flag is never read in the edge that changes it
    task automatic wait_idle(input int limit);
        @(negedge sys_clk);
        for (int i = 0; i < limit && dump_active !== 1'b0; i++) @(negedge sys_clk);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        check("reset line", serial_out, 1'b1);
        check("reset pins", {integ_reset, integ_run, integ_capture, hold_valid, dump_active, sleep}, 6'h20);
        check("reset cfg", analog_cfg, 64'h0);
        nrst <= 1'b1;
        ctl.idle(12);
        ctl.drive_bits(32'h0, 12);
        ctl.idle(3);
        cmd_at({`KIND_REG_FETCH, 5'h01}, 4);
        for (int i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            check("unsettled line", serial_out, 1'b1);
        end
        cmd_at(`CMD_MAIN_RESET, 34);
        // gains and offsets go in before any dump; mode only ever gets 0x00 or 0x10
        for (int i = 0; i < 8; i++) reg_write(addrs[i], vals[i]);
        for (int i = 0; i < 8; i++) begin
            reg_read(addrs[i], (i == 7) ? 8'h00 : ((i < 6 && i % 2 == 1) ? (vals[i] & 8'h1f) : vals[i]));
        end
        exp_cfg = '0;
        for (int z = 0; z < 3; z++) begin
            exp_cfg.zone[z].offset = vals[2 * z];
            exp_cfg.zone[z].gain = vals[2 * z + 1][4:0];
        end
        exp_cfg.mode = vals[6];
        check("cfg pins", 64'(analog_cfg), 64'(exp_cfg));
        // half a byte then a long zero run: without resync the next read is misframed
        ctl.drive_bits(32'h0000000e, 16);
        ctl.idle(1);
        reg_read(5'h01, 8'h1c);
        ctl.idle(20000);
        cmd_at(`CMD_BEGIN_INTEGRATE, 21);
        @(negedge sys_clk);
        check("pixel reset", {integ_run, integ_reset}, 2'b01);
        ctl.idle(1);
        @(negedge sys_clk);
        check("integrating", {integ_run, integ_reset}, 2'b10);
        cmd_at(`CMD_SAMPLE_HOLD, 1);
        @(negedge sys_clk);
        check("sample start", {integ_reset, integ_run, integ_capture}, 3'h5);
        ctl.idle(100);
        @(negedge sys_clk);
        check("hold early", hold_valid, 1'b0);
        ctl.idle(1);
        @(negedge sys_clk);
        check("hold filled", hold_valid, 1'b1);
        cmd_at(`CMD_PIXEL_DUMP, 44);
        check("dump lead", serial_out, 1'b1);
        fork
            dump_frames(102);
            begin
                ctl.idle(200);
                reg_write(5'h04, 8'h66);
            end
        join
        wait_idle(20);
        check("dump over", dump_active, 1'b0);
        check("store in dump", analog_cfg.zone[2].offset, 8'h66);
        reg_write(`REG_MODE, 8'h10);
        check("asleep", sleep, 1'b1);
        cmd_at(`CMD_PIXEL_DUMP, 44);
        ctl.rx_frame(frm);
        check("sleep framing", {frm[9], frm[0]}, 2'b10);
        cmd_at(`CMD_MAIN_RESET, 5);
        check("reset stop", {dump_active, hold_valid, integ_reset, integ_run}, 4'h2);
        ctl.idle(34);
        check("reset quiet", serial_out, 1'b1);
        reg_write(`REG_MODE, 8'h00);
        check("awake", sleep, 1'b0);
        ctl.idle(20000);
        cmd_at(`CMD_SAMPLE_DUMP, 44);
        dump_frames(3);
        // the whole readout drains before the next sample
        wait_idle(1100);
        check("combo hold", {hold_valid, dump_active}, 2'b10);
        cmd_at(`CMD_SAMPLE_DUMP_RESTART, 21);
        @(negedge sys_clk);
        check("restart wait", integ_run, 1'b0);
        ctl.idle(1);
        @(negedge sys_clk);
        check("restart run", integ_run, 1'b1);
        ctl.idle(22);
        check("restart lead", serial_out, 1'b1);
        dump_frames(2);
        cmd_at(`CMD_DUMP_ABORT, 5);
        check("abort stop", {dump_active, hold_valid, integ_reset, integ_run}, 4'h2);
        ctl.idle(12);
        check("abort quiet", serial_out, 1'b1);
        finish_test();
    end

    initial begin
        repeat (50000) @(posedge sys_clk);
        mismatches++;
        finish_test();
    end
endmodule
